// [core/gma_arbiter.sv]
// global bus arbiter and main memory arbiter
// assumes all inputs synchronous to clock_in; requests stay up until granted
`timescale 1ns/1ps
module gma_arbiter (
  input  wire logic                   clock_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   host_bus_request_n_in,
  input  wire logic                   host_all_bus_request_n_in,
  input  wire logic                   host_lock_n_in,
  input  wire logic [2:0]             local_master_request_n_in,
  input  wire logic                   periph_hold_request_in,
  input  wire logic                   dirty_line_n_in,
  input  wire logic                   intervention_done_in,
  input  wire logic                   bus_cycle_end_in,
  input  wire logic                   isa_refresh_enable_in,
  input  wire logic                   mem_refresh_request_in,
  input  wire gma_pkg::gma_read_src_s read_src_in,
  input  wire logic                   mem_write_request_in,
  input  wire logic                   read_hits_queued_write_in,
  input  wire logic                   mem_access_done_in,
  output gma_pkg::gma_grant_s         grant_out,
  output logic                        last_grant_was_isa_out,
  output logic                        isa_refresh_active_out,
  output logic                        isa_refresh_ack_out,
  output gma_pkg::gma_mem_e           mem_state_out,
  output logic                        mem_busy_out,
  output logic                        prefetch_start_out
);
  import gma_pkg::*;

  gma_global_e state;
  gma_global_e next_state;
  gma_global_e return_state;
  gma_mem_e    mem_state;
  gma_mem_e    next_mem_state;
  logic [2:0]  local_pend;
  logic [1:0]  local_ptr;
  logic [1:0]  local_owner;
  logic [1:0]  next_owner;
  logic        host_turn_done;
  logic        isa_refresh_req;
  logic        isa_req_is_refresh;
  logic        host_wants_buses;
  logic        host_all_lock;
  logic        local_master_wants_buses;
  logic        isa_side_wants_buses;
  logic        intervention_request;
  logic        intervention_in_progress;
  logic        pick_found;
  logic        mem_read_request;
  logic        read_first;
  logic [2:0]  local_req;
  logic [1:0]  cand;

  assign local_req = ~local_master_request_n_in;
  // any of the three host signals counts as one request
  assign host_wants_buses = ~host_bus_request_n_in |
                            ~host_all_bus_request_n_in |
                            ~host_lock_n_in;
  assign host_all_lock = ~host_all_bus_request_n_in |
                         ~host_lock_n_in;
  assign isa_side_wants_buses = isa_refresh_req | periph_hold_request_in;
  assign intervention_request = ~dirty_line_n_in;
  assign intervention_in_progress = (state == GMA_INTERVENE);
  assign local_master_wants_buses = |(local_pend & local_req);

  gma_refresh_timer u_refresh (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .enable_in   (isa_refresh_enable_in),
    .ack_in      (isa_refresh_ack_out),
    .request_out (isa_refresh_req)
  );

  // rotating pick within the latched pending set: 2 then 0 then 1
  always_comb begin
    next_owner = local_ptr;
    pick_found = 1'b0;
    cand       = 2'h0;
    for (int i = 0; i < 3; i++) begin
      cand = 2'((int'(local_ptr) + i) % 3);
      // rotation order 2,0,1 is ptr+1 modulo three starting at 2
      if (!pick_found && local_pend[cand] && local_req[cand]) begin
        next_owner = cand;
        pick_found = 1'b1;
      end
    end
  end

  // global arbiter next state
  always_comb begin
    next_state = state;
    case (state)
      GMA_HOST: begin
        // host keeps grant unless idle and another party waits
        if (intervention_request) begin
          next_state = GMA_INTERVENE;
        end else if (!host_wants_buses && !host_all_lock &&
                     (isa_side_wants_buses ||
                      (local_master_wants_buses && host_turn_done)) &&
                     bus_cycle_end_in) begin
          next_state = GMA_HOST_WAIT;
        end
      end
      GMA_HOST_WAIT: begin
        // second of the two clocks; host can still reclaim here
        if (host_wants_buses) begin
          next_state = GMA_HOST;
        end else if (isa_side_wants_buses &&
                     (!last_grant_was_isa_out || !local_master_wants_buses)) begin
          next_state = GMA_ISA;
        end else if (local_master_wants_buses) begin
          next_state = GMA_LOCAL;
        end else begin
          next_state = GMA_HOST;
        end
      end
      GMA_ISA: begin
        if (intervention_request) begin
          next_state = GMA_INTERVENE;
        end else if (isa_req_is_refresh ? !isa_refresh_req
                                        : !periph_hold_request_in) begin
          // the served source withdrew; host gets its turn before the other
          next_state = GMA_HOST;
        end
      end
      GMA_LOCAL: begin
        if (intervention_request) begin
          next_state = GMA_INTERVENE;
        end else if (!local_req[local_owner]) begin
          next_state = GMA_HOST;
        end
      end
      GMA_INTERVENE: begin
        if (intervention_done_in) begin
          next_state = return_state;
        end
      end
      default: next_state = GMA_HOST;
    endcase
  end

  // state register; reset enters host grant
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= GMA_HOST;
    end else begin
      state <= next_state;
    end
  end

  // where to resume after an intervention cycle
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      return_state <= GMA_HOST;
    end else if (next_state == GMA_INTERVENE && state != GMA_INTERVENE) begin
      return_state <= (state == GMA_HOST_WAIT) ? GMA_HOST : state;
    end
  end

  // last non host grant memory
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_grant_was_isa_out <= 1'b0;
    end else if (state == GMA_HOST_WAIT && next_state == GMA_ISA) begin
      last_grant_was_isa_out <= 1'b1;
    end else if (state == GMA_HOST_WAIT && next_state == GMA_LOCAL) begin
      last_grant_was_isa_out <= 1'b0;
    end
  end

  // host turn after each local grant before the next local master
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_turn_done <= 1'b1;
    end else if (state == GMA_LOCAL) begin
      host_turn_done <= 1'b0;
    end else if (state == GMA_HOST && !isa_side_wants_buses) begin
      host_turn_done <= 1'b1;
    end
  end

  // pending register loaded only when no pending master still requests, drained grant by grant
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      local_pend  <= LOCAL_PEND_RESET;
      local_ptr   <= LOCAL_PTR_RESET;
      local_owner <= 2'h0;
    end else if (state == GMA_HOST_WAIT && next_state == GMA_LOCAL) begin
      local_pend[next_owner] <= 1'b0;
      local_owner <= next_owner;
      local_ptr   <= (next_owner == 2'h2) ? 2'h0 : next_owner + 2'h1;
    end else if ((local_pend & local_req) == 3'h0) begin
      local_pend <= local_req;
    end
  end

  // grants, all registered
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      grant_out <= '0;
      grant_out.host <= 1'b1;
    end else begin
      grant_out.host      <= (next_state == GMA_HOST);
      grant_out.isa       <= (next_state == GMA_ISA);
      grant_out.intervene <= (next_state == GMA_INTERVENE);
      grant_out.local_m   <= 3'h0;
      if (next_state == GMA_LOCAL) begin
        // only a host wait pick is new; a resumed grant keeps its owner
        grant_out.local_m[(state == GMA_HOST_WAIT) ? next_owner
                                                   : local_owner] <= 1'b1;
      end
    end
  end

  // refresh before dma when both pend; ack when the isa grant starts
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      isa_req_is_refresh     <= 1'b0;
      isa_refresh_ack_out    <= 1'b0;
      isa_refresh_active_out <= 1'b0;
    end else begin
      isa_refresh_ack_out <= 1'b0;
      if (state == GMA_HOST_WAIT && next_state == GMA_ISA) begin
        isa_req_is_refresh  <= isa_refresh_req;
        isa_refresh_ack_out <= isa_refresh_req;
      end
      isa_refresh_active_out <= (next_state == GMA_ISA) &&
        ((state == GMA_HOST_WAIT) ? isa_refresh_req : isa_req_is_refresh);
    end
  end

  // memory side: reads from any queue or a prefetch count as reads
  assign mem_read_request = read_src_in.prefetch_half_empty |
                            read_src_in.local_read |
                            read_src_in.isa_read;
  assign read_first = mem_read_request && !read_hits_queued_write_in;

  // priority pick, rechecked only from idle
  always_comb begin
    next_mem_state = mem_state;
    case (mem_state)
      GMA_MEM_IDLE: begin
        if (mem_refresh_request_in &&
            (mem_read_request || mem_write_request_in)) begin
          next_mem_state = GMA_MEM_REFRESH;
        end else if (read_first) begin
          next_mem_state = GMA_MEM_READ;
        end else if (mem_write_request_in) begin
          next_mem_state = GMA_MEM_WRITE;
        end else if (mem_refresh_request_in) begin
          next_mem_state = GMA_MEM_REFRESH;
        end
      end
      GMA_MEM_REFRESH, GMA_MEM_READ, GMA_MEM_WRITE: begin
        if (mem_access_done_in) begin
          next_mem_state = GMA_MEM_IDLE;
        end
      end
      default: next_mem_state = GMA_MEM_IDLE;
    endcase
  end

  // memory state register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_state <= GMA_MEM_IDLE;
    end else begin
      mem_state <= next_mem_state;
    end
  end

  // registered memory outputs
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_state_out      <= GMA_MEM_IDLE;
      mem_busy_out       <= 1'b0;
      prefetch_start_out <= 1'b0;
    end else begin
      mem_state_out <= next_mem_state;
      mem_busy_out  <= (next_mem_state != GMA_MEM_IDLE);
      // prefetch starts only when no real read is waiting
      prefetch_start_out <= (mem_state == GMA_MEM_IDLE) &&
                            (next_mem_state == GMA_MEM_READ) &&
                            read_src_in.prefetch_half_empty &&
                            !read_src_in.local_read &&
                            !read_src_in.isa_read;
    end
  end
endmodule

// [common/gma_pkg.sv]
// constants, states and carriers for the global and memory arbiter
// assumes a single 125 MHz clock and request inputs already synchronous
//
// Contract
// - reset puts the global arbiter in the host grant state.
// - host grant holds while host requests or nobody else requests.
// - after another master releases, host gets a chance before others.
// - local grant ends on request withdrawal or cache hit intervention.
// - isa grant on refresh or dma hold when host idle; ends likewise.
// - cache hit read moves to intervention grant until cycle finishes.
// - any host request or lock signal grants all buses to host.
// - host grant to isa or local grant takes two clocks.
// - every move into or out of intervention takes one clock.
// - local priority rotates master 2, then 0, then 1, then 2.
// - a further local master waits for host then pending isa turn.
// - three separate active low local master request lines.
// - enabled isa refresh logic requests every 15 microseconds.
// - isa refresh wins over dma hold when both pend.
// - remember whether last non host grant went to isa or local.
// - memory rank: urgent refresh, reads, writes, idle refresh.
// - a read hitting a queued write waits for that write first.
// - half empty prefetch queue starts a block prefetch as a read.
// - snoop write backs are arbitrated as ordinary writes.
// - reads come from prefetch, local or isa read queues.
// - memory arbiter leaves reset idle.
// - host grant stays asserted while nobody else requests.
// - all bus request keeps buses locked until host negates it.
// - pending local register loads only when empty, drains fully; the code reloads it once no pending master still requests.
package gma_pkg;
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned ISA_REFRESH_US   = 15;
  localparam int unsigned ISA_REFRESH_CYC  = ISA_REFRESH_US * CLK_MHZ;
  localparam int unsigned HOST_TO_OTHER_CYC = 2;
  localparam logic [2:0]  LOCAL_PEND_RESET = 3'h0;
  localparam logic [1:0]  LOCAL_PTR_RESET  = 2'h2;

  typedef enum logic [2:0] {
    GMA_HOST, GMA_HOST_WAIT, GMA_ISA, GMA_LOCAL, GMA_INTERVENE
  } gma_global_e;

  typedef enum logic [2:0] {
    GMA_MEM_IDLE, GMA_MEM_REFRESH, GMA_MEM_READ, GMA_MEM_WRITE
  } gma_mem_e;

  typedef struct packed {
    logic host;
    logic isa;
    logic [2:0] local_m;
    logic intervene;
  } gma_grant_s;

  typedef struct packed {
    logic prefetch_half_empty;
    logic local_read;
    logic isa_read;
  } gma_read_src_s;
endpackage

// [core/gma_refresh_timer.sv]
// periodic isa refresh request generator
// assumes the arbiter acknowledges a request by a one-cycle pulse
`timescale 1ns/1ps
module gma_refresh_timer #(
  parameter int unsigned PERIOD_CYC = gma_pkg::ISA_REFRESH_CYC
) (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic enable_in,
  input  wire logic ack_in,
  output logic      request_out
);
  import gma_pkg::*;

  logic [15:0] count;

  // free counter; held in reset when disabled so no stale request appears
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= 16'h0;
    end else if (!enable_in || count == 16'(PERIOD_CYC - 1)) begin
      count <= 16'h0;
    end else begin
      count <= count + 16'h1;
    end
  end

  // sticky request, a new tick wins over the acknowledge
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      request_out <= 1'b0;
    end else if (!enable_in) begin
      request_out <= 1'b0;
    end else if (count == 16'(PERIOD_CYC - 1)) begin
      request_out <= 1'b1;
    end else if (ack_in) begin
      request_out <= 1'b0;
    end
  end
endmodule

// [test/gma_checker.sv]
// assertions on the ports of the arbiter top module
// assumes gma_pkg is compiled first; the bind below attaches it
`timescale 1ns/1ps
module gma_checker (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic host_bus_request_n_in,
  input wire logic host_all_bus_request_n_in,
  input wire logic host_lock_n_in,
  input wire logic [2:0] local_master_request_n_in,
  input wire logic periph_hold_request_in,
  input wire logic dirty_line_n_in,
  input wire logic intervention_done_in,
  input wire logic bus_cycle_end_in,
  input wire logic isa_refresh_enable_in,
  input wire logic mem_refresh_request_in,
  input wire gma_pkg::gma_read_src_s read_src_in,
  input wire logic mem_write_request_in,
  input wire logic read_hits_queued_write_in,
  input wire logic mem_access_done_in,
  input wire gma_pkg::gma_grant_s grant_out,
  input wire logic last_grant_was_isa_out,
  input wire logic isa_refresh_active_out,
  input wire logic isa_refresh_ack_out,
  input wire gma_pkg::gma_mem_e mem_state_out,
  input wire logic mem_busy_out,
  input wire logic prefetch_start_out
);
  import gma_pkg::*;
  // any of the three host signals counts alike as a host request
  wire logic host_wants = !host_bus_request_n_in ||
    !host_all_bus_request_n_in || !host_lock_n_in;
  wire logic other = grant_out.isa || grant_out.local_m != 3'h0;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  reset_idle_a: assert property ($rose(rst_n_in) |->
    grant_out == 6'h20 && !mem_busy_out) else $error("reset state");
  host_keep_a: assert property (
    grant_out.host && dirty_line_n_in && (host_wants || !bus_cycle_end_in)
    |=> grant_out.host) else $error("host lost buses");
  host_idle_a: assert property (grant_out.host &&
    dirty_line_n_in &&
    &local_master_request_n_in && !periph_hold_request_in &&
    !isa_refresh_enable_in |=> grant_out.host) else $error("host dropped");
  two_clock_a: assert property (
    $fell(grant_out.host) && !grant_out.intervene |->
    grant_out == 6'h0 ##1 other) else $error("host to other not 2");
  dcl_enter_a: assert property (other && !dirty_line_n_in
    |=> grant_out.intervene) else $error("no intervention");
  dcl_hold_a: assert property (grant_out.intervene &&
    !intervention_done_in |=> grant_out.intervene) else $error("dcl left");
  dcl_leave_a: assert property (grant_out.intervene &&
    intervention_done_in |=> !grant_out.intervene && grant_out != 6'h0)
    else $error("dcl exit not 1");
  local_end_a: assert property (
    grant_out.local_m != 3'h0 && dirty_line_n_in &&
    (grant_out.local_m & ~local_master_request_n_in) == 3'h0
    |=> grant_out.host) else $error("host skipped");
  mem_one_a: assert property (mem_busy_out &&
    !mem_access_done_in |=> $stable(mem_state_out)) else $error("mem moved");
  mem_rank_a: assert property (!mem_busy_out &&
    mem_refresh_request_in |=> mem_state_out == GMA_MEM_REFRESH)
    else $error("refresh not first");
  refresh_ack_a: assert property (isa_refresh_ack_out |->
    grant_out.isa && isa_refresh_active_out) else $error("ack no grant");
endmodule

bind gma_arbiter gma_checker chk (.*);

// [test/gma_far_side.sv]
// far side model: three local masters and the peripheral hold line
// assumes grants are registered and requests move on falling edges
`timescale 1ns/1ps
module gma_far_side #(
  parameter int unsigned USE_CYC = 4
) (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic [2:0] go_in,
  input  wire logic [2:0] granted_in,
  input  wire logic [2:0] hold_src_in,
  output logic      [2:0] request_n_out,
  output logic            hold_out
);
  int unsigned used [3];
  // dma, isa refresh and isa master merge into one hold line
  assign hold_out = |hold_src_in;
  // each master owns its line, uses the buses a while, then lets go
  // and stays quiet until its go drops, so a withdrawal is real
  always @(negedge clock_in or negedge rst_n_in) begin
    for (int i = 0; i < 3; i++) begin
      if (!rst_n_in) begin
        request_n_out[i] <= 1'b1;
        used[i] <= 0;
      end else if (!go_in[i] || used[i] == USE_CYC) begin
        request_n_out[i] <= 1'b1;
        used[i] <= go_in[i] ? used[i] : 0;
      end else begin
        request_n_out[i] <= 1'b0;
        used[i] <= used[i] + (granted_in[i] ? 1 : 0);
      end
    end
  end
endmodule

// [test/test_global_and_memory_arbiter.sv]
// self-checking bench for the global and memory arbiter
// assumes gma_pkg, gma_arbiter, gma_far_side and the checker compiled
`timescale 1ns/1ps
module test_global_and_memory_arbiter;
  import gma_pkg::*;
  logic clock_in, rst_n_in, dirty_line_n_in, bus_cycle_end_in;
  logic host_bus_request_n_in, host_all_bus_request_n_in, host_lock_n_in;
  logic periph_hold_request_in, intervention_done_in, mem_busy_out;
  logic isa_refresh_enable_in, mem_refresh_request_in, prefetch_start_out;
  logic mem_write_request_in, read_hits_queued_write_in;
  logic mem_access_done_in, last_grant_was_isa_out, isa_refresh_ack_out;
  logic isa_refresh_active_out;
  logic [2:0] local_master_request_n_in, go, hold_src;
  gma_read_src_s read_src_in;
  gma_grant_s grant_out;
  gma_mem_e mem_state_out;
  int miscompares, checks;

  gma_arbiter DUT (.*);
  gma_far_side far (.clock_in, .rst_n_in, .go_in(go),
    .granted_in(grant_out.local_m), .hold_src_in(hold_src),
    .request_n_out(local_master_request_n_in),
    .hold_out(periph_hold_request_in));

  // 125 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // polls on falling edges so grants have settled; gives up after 100
  task automatic wait_grant(input logic [5:0] mask);
    for (int i = 0; i < 100 && (grant_out & mask) == 6'h0; i++) tick(1);
  endtask

  // host lock and mid-cycle hold off master 2, which then goes first
  task automatic t_host;
    {host_all_bus_request_n_in, host_lock_n_in} = 2'h0;
    go = 3'h4;
    tick(20);
    check("lock held", grant_out, 6'h20);
    {host_all_bus_request_n_in, host_lock_n_in} = 2'h3;
    bus_cycle_end_in = 1'b0;
    tick(10);
    check("cycle end", grant_out, 6'h20);
    bus_cycle_end_in = 1'b1;
    wait_grant(6'h0e);
    check("first local", grant_out, 6'h08);
    check("last isa", last_grant_was_isa_out, 1'b0);
    wait_grant(6'h20);
    go = 3'h0;
    tick(2); // far side must see go low once to rearm
  endtask

  // all three ask at once; the host gets a turn between local grants
  task automatic t_rotate;
    logic [5:0] order [3] = '{6'h02, 6'h04, 6'h08};
    go = 3'h7;
    for (int k = 0; k < 3; k++) begin
      wait_grant(6'h0e);
      check("rotation", grant_out, order[k]);
      wait_grant(6'h20);
      check("host turn", grant_out, 6'h20);
    end
    go = 3'h0;
    tick(2); // far side must see go low once to rearm
  endtask

  // a cache hit during a local grant moves the buses to the intervention grant
  task automatic t_intervene;
    go = 3'h1;
    wait_grant(6'h0e);
    dirty_line_n_in = 1'b0;
    tick(3);
    check("intervene", grant_out, 6'h01);
    dirty_line_n_in = 1'b1;
    intervention_done_in = 1'b1;
    tick(1);
    intervention_done_in = 1'b0;
    check("resume", grant_out, 6'h02);
    wait_grant(6'h20);
    go = 3'h0;
    tick(2); // far side must see go low once to rearm
  endtask

  // refresh and dma both wait behind the host; refresh is served first
  task automatic t_isa;
    host_bus_request_n_in = 1'b0;
    isa_refresh_enable_in = 1'b1;
    hold_src = 3'h1;
    tick(2000);
    host_bus_request_n_in = 1'b1;
    wait_grant(6'h10);
    check("refresh first", isa_refresh_active_out, 1'b1);
    wait_grant(6'h20);
    wait_grant(6'h10);
    check("dma grant", isa_refresh_active_out, 1'b0);
    check("last isa", last_grant_was_isa_out, 1'b1);
    hold_src = 3'h0;
    wait_grant(6'h20);
    check("dma done", grant_out, 6'h20);
  endtask

  // refresh acks come one period apart and stop once disabled
  task automatic t_period;
    int n = 0;
    for (int i = 0; i < 2000 && isa_refresh_ack_out !== 1'b1; i++) tick(1);
    do begin
      tick(1);
      n++;
    end while (isa_refresh_ack_out !== 1'b1 && n < 3000);
    check("period", 16'(n), 16'(ISA_REFRESH_CYC));
    isa_refresh_enable_in = 1'b0;
    n = 0;
    repeat (4000) begin
      tick(1);
      n += (isa_refresh_ack_out === 1'b1) ? 1 : 0;
    end
    check("gated", 16'(n), 16'h0);
  endtask

  // one idle pick per row: {refresh, read sources, write, hit}
  task automatic t_mem;
    logic [9:0] tbl [7] = '{{6'h10, GMA_MEM_READ, 1'b1},
      {6'h08, GMA_MEM_READ, 1'b0}, {6'h06, GMA_MEM_READ, 1'b0},
      {6'h07, GMA_MEM_WRITE, 1'b0}, {6'h02, GMA_MEM_WRITE, 1'b0},
      {6'h28, GMA_MEM_REFRESH, 1'b0}, {6'h20, GMA_MEM_REFRESH, 1'b0}};
    foreach (tbl[k]) begin
      {mem_refresh_request_in, read_src_in, mem_write_request_in,
        read_hits_queued_write_in} = tbl[k][9:4];
      for (int i = 0; i < 50 && mem_busy_out !== 1'b1; i++) tick(1);
      check("mem pick", mem_state_out, tbl[k][3:1]);
      check("prefetch", prefetch_start_out, tbl[k][0]);
      {mem_refresh_request_in, read_src_in, mem_write_request_in,
        read_hits_queued_write_in} = 6'h0;
      tick(3);
      check("mem hold", mem_state_out, tbl[k][3:1]);
      mem_access_done_in = 1'b1;
      tick(1);
      mem_access_done_in = 1'b0;
      check("mem idle", mem_busy_out, 1'b0);
    end
  endtask

  // reset for six cycles, then the scenarios in order
  initial begin
    rst_n_in = 1'b0;
    {host_bus_request_n_in, host_all_bus_request_n_in} = 2'h3;
    {host_lock_n_in, dirty_line_n_in, bus_cycle_end_in} = 3'h7;
    {intervention_done_in, isa_refresh_enable_in} = 2'h0;
    {mem_refresh_request_in, mem_write_request_in} = 2'h0;
    {read_hits_queued_write_in, mem_access_done_in} = 2'h0;
    read_src_in = 3'h0;
    go = 3'h0;
    hold_src = 3'h0;
    repeat (6) @(negedge clock_in);
    rst_n_in = 1'b1;
    tick(1);
    check("reset grant", grant_out, 6'h20);
    check("reset mem", mem_state_out, GMA_MEM_IDLE);
    t_host;
    t_rotate;
    t_intervene;
    t_isa;
    t_period;
    t_mem;
    results;
  end

  // the run needs about 10000 cycles; twice that means a hang
  initial begin
    repeat (20000) @(posedge clock_in);
    miscompares++;
    results;
  end
endmodule
